// *** rtl/ppei_pkg.sv ***
// Package for the port pin edge interrupt block: register offsets, widths, pin masks.
// Assumes an 8-bit register port with word-indexed offsets.
package ppei_pkg;

    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_T_ENABLE = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_T_FLAGS = 4'h1;
    localparam logic [ADDR_W-1:0] OFF_S_ENABLE = 4'h2;
    localparam logic [ADDR_W-1:0] OFF_S_FLAGS = 4'h3;
    localparam logic [ADDR_W-1:0] OFF_AD_ENABLE = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_AD_FLAGS = 4'h5;
    localparam logic [ADDR_W-1:0] OFF_R_ENABLE = 4'h6;
    localparam logic [ADDR_W-1:0] OFF_R_FLAGS = 4'h7;
    localparam logic [ADDR_W-1:0] OFF_T_POLARITY = 4'h8;
    localparam logic [ADDR_W-1:0] OFF_S_POLARITY = 4'h9;
    localparam logic [ADDR_W-1:0] OFF_R_POLARITY = 4'ha;

    // ----------------------------------------------------------------
    // Implemented pins per port
    // ----------------------------------------------------------------
    localparam logic [DATA_W-1:0] MASK_T = 8'h60;
    localparam logic [DATA_W-1:0] MASK_S = 8'h60;
    localparam logic [DATA_W-1:0] MASK_AD = 8'hff;
    localparam logic [DATA_W-1:0] MASK_R = 8'h0f;

    localparam logic [DATA_W-1:0] RST_ZERO = 8'h00;

    // Pins of all four ports travel together
    typedef struct packed {
        logic [DATA_W-1:0] t;
        logic [DATA_W-1:0] s;
        logic [DATA_W-1:0] ad;
        logic [DATA_W-1:0] r;
    } ppei_pins_s;

    typedef struct packed {
        logic t;
        logic s;
        logic ad;
        logic r;
    } ppei_irq_s;

endpackage

// *** rtl/ppei_top.sv ***
// Edge-sensitive pin interrupt flags and enables for ports T, S, AD and R; polarity for T, S and R.
// Assumes pins are asynchronous to clk and a single-cycle register port master.
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/10ps

// Contract
// R1: Port T pins 6-5 set their flag on the polarity-selected active edge.
// R2: Writing one to a port T flag bit clears exactly that flag.
// R3: Port S pins 6-5 each have an interrupt enable bit.
// R4: Port S pins 6-5 set their flag on the polarity-selected active edge.
// R5: Writing one to a port S flag bit clears that flag.
// R6: Port AD pins 7-0 each have an interrupt enable bit.
// R7: Port AD flags set only on falling edges, no polarity choice.
// R8: Writing one to a port AD flag bit clears that flag.
// R9: Port R pins 3-0 each have an interrupt enable bit.
// R10: Port R pins 3-0 set their flag on the polarity-selected active edge.
// R11: Writing one to a port R flag bit clears that flag.
// R12: Writing zero to a flag bit leaves it unchanged.
// R13: Interrupt requested while a flag is set and its enable is one.
// R14: Enable zero masks the flag from the request; edges still set it.
// R15: Software disables the LCD frontplane function before port T wakeup.
// R16: Software sets the analog pin digital input enable before port AD wakeup.
// R17: Polarity one selects rising edge with pull-down; zero selects falling with pull-up.
// R18: Pins are synchronised; current and previous samples compared, one set per edge.
// R19: One request per port: OR of enabled flags; set beats simultaneous clear.
module ppei_top
    import ppei_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // Pins
    input wire ppei_pins_s pin_in,
    // Pull device selection per pin, one means pull-down
    output ppei_pins_s pull_down_sel,
    // Interrupt requests
    output ppei_irq_s irq_port,
    output logic irq
);

    ppei_pins_s sync1;
    ppei_pins_s sync2;
    ppei_pins_s prev;
    ppei_pins_s flags;
    ppei_pins_s enable;
    ppei_pins_s next_flags;
    ppei_pins_s edge_hit;
    ppei_pins_s clr;
    logic [DATA_W-1:0] pol_t;
    logic [DATA_W-1:0] pol_s;
    logic [DATA_W-1:0] pol_r;

    function automatic logic [DATA_W-1:0] active_edge(input logic [DATA_W-1:0] cur,
                                                      input logic [DATA_W-1:0] old,
                                                      input logic [DATA_W-1:0] pol);
        // Rising where polarity is one, falling where zero
        active_edge = (cur & ~old & pol) | (~cur & old & ~pol);
    endfunction

    function automatic logic [DATA_W-1:0] w1c(input logic hit);
        w1c = hit ? reg_wdata : RST_ZERO;
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // Two stages guard against metastability; a third holds the previous sample.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1 <= '0;
            sync2 <= '0;
            prev <= '0;
        end else begin
            sync1 <= pin_in;
            sync2 <= sync1; // [R18]
            prev <= sync2; // [R18]
        end
    end

    // ----------------------------------------------------------------
    // Edge detection and flag update
    // ----------------------------------------------------------------
    always_comb begin
        edge_hit.t = active_edge(sync2.t, prev.t, pol_t) & MASK_T; // [R1] [R17] [R18]
        edge_hit.s = active_edge(sync2.s, prev.s, pol_s) & MASK_S; // [R4] [R17]
        edge_hit.ad = active_edge(sync2.ad, prev.ad, RST_ZERO) & MASK_AD; // [R7]
        edge_hit.r = active_edge(sync2.r, prev.r, pol_r) & MASK_R; // [R10] [R17]
        // Only ones in the write data clear; zeros leave flags alone
        clr.t = w1c(reg_wr && reg_addr == OFF_T_FLAGS); // [R2] [R12]
        clr.s = w1c(reg_wr && reg_addr == OFF_S_FLAGS); // [R5] [R12]
        clr.ad = w1c(reg_wr && reg_addr == OFF_AD_FLAGS); // [R8] [R12]
        clr.r = w1c(reg_wr && reg_addr == OFF_R_FLAGS); // [R11] [R12]
        // Edge wins over a clear in the same cycle, so no event is lost
        next_flags = (flags & ~clr) | edge_hit; // [R19]
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flags <= '0;
        end else begin
            flags <= next_flags;
        end
    end

    // ----------------------------------------------------------------
    // Enable and polarity registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            enable <= '0;
        end else if (reg_wr) begin
            case (reg_addr)
                OFF_T_ENABLE: enable.t <= reg_wdata & MASK_T;
                OFF_S_ENABLE: enable.s <= reg_wdata & MASK_S; // [R3]
                OFF_AD_ENABLE: enable.ad <= reg_wdata & MASK_AD; // [R6]
                OFF_R_ENABLE: enable.r <= reg_wdata & MASK_R; // [R9]
                default: enable <= enable;
            endcase
        end
    end

    // Polarity bits are full width since they also steer the pull devices
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pol_t <= RST_ZERO;
            pol_s <= RST_ZERO;
            pol_r <= RST_ZERO;
        end else if (reg_wr) begin
            case (reg_addr)
                OFF_T_POLARITY: pol_t <= reg_wdata;
                OFF_S_POLARITY: pol_s <= reg_wdata;
                OFF_R_POLARITY: pol_r <= reg_wdata;
                default: pol_t <= pol_t;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pull_down_sel <= '0;
        end else begin
            pull_down_sel.t <= pol_t; // [R17]
            pull_down_sel.s <= pol_s;
            pull_down_sel.ad <= RST_ZERO;
            pull_down_sel.r <= pol_r;
        end
    end

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= RST_ZERO;
        end else if (reg_rd) begin
            case (reg_addr)
                OFF_T_ENABLE: reg_rdata <= enable.t;
                OFF_T_FLAGS: reg_rdata <= flags.t;
                OFF_S_ENABLE: reg_rdata <= enable.s;
                OFF_S_FLAGS: reg_rdata <= flags.s;
                OFF_AD_ENABLE: reg_rdata <= enable.ad;
                OFF_AD_FLAGS: reg_rdata <= flags.ad;
                OFF_R_ENABLE: reg_rdata <= enable.r;
                OFF_R_FLAGS: reg_rdata <= flags.r;
                OFF_T_POLARITY: reg_rdata <= pol_t;
                OFF_S_POLARITY: reg_rdata <= pol_s;
                OFF_R_POLARITY: reg_rdata <= pol_r;
                default: reg_rdata <= RST_ZERO;
            endcase
        end else begin
            reg_rdata <= RST_ZERO;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt requests
    // ----------------------------------------------------------------
    // Registered from next values so the request tracks flags with no added lag
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_port <= '0;
            irq <= 1'b0;
        end else begin
            irq_port.t <= |(next_flags.t & enable.t); // [R13] [R14] [R19]
            irq_port.s <= |(next_flags.s & enable.s); // [R13] [R14]
            irq_port.ad <= |(next_flags.ad & enable.ad); // [R13] [R14]
            irq_port.r <= |(next_flags.r & enable.r); // [R13] [R14]
            irq <= |(next_flags & enable);
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    // Decoded strobes keep the properties short; they feed no logic
    logic wr_t_flags;
    logic wr_s_flags;
    logic wr_ad_flags;
    logic wr_r_flags;
    logic wr_s_enable;
    logic wr_ad_enable;
    logic wr_r_enable;
    logic wr_r_polarity;

    assign wr_t_flags = reg_wr && reg_addr == OFF_T_FLAGS;
    assign wr_s_flags = reg_wr && reg_addr == OFF_S_FLAGS;
    assign wr_ad_flags = reg_wr && reg_addr == OFF_AD_FLAGS;
    assign wr_r_flags = reg_wr && reg_addr == OFF_R_FLAGS;
    assign wr_s_enable = reg_wr && reg_addr == OFF_S_ENABLE;
    assign wr_ad_enable = reg_wr && reg_addr == OFF_AD_ENABLE;
    assign wr_r_enable = reg_wr && reg_addr == OFF_R_ENABLE;
    assign wr_r_polarity = reg_wr && reg_addr == OFF_R_POLARITY;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // ----------------------------------------------------------------
    // Port T
    // ----------------------------------------------------------------
    AST_T_EDGE_SETS: assert property (edge_hit.t[5] |=> flags.t[5]) // [R1]
        else $error("port T edge did not set flag");

    AST_T_FALL_SETS: assert property ( // [R1] [R17]
        !pol_t[6] && !sync2.t[6] && prev.t[6]
        |=> flags.t[6])
        else $error("port T falling edge missed");

    AST_T_CLEAR: assert property ( // [R2]
        wr_t_flags && reg_wdata[6] && !edge_hit.t[6]
        |=> !flags.t[6])
        else $error("port T flag not cleared by one");

    AST_T_CLEAR_ONLY: assert property ( // [R2]
        wr_t_flags && !reg_wdata[5] && flags.t[5]
        |=> flags.t[5])
        else $error("port T clear touched another flag");

    AST_T_UNUSED_ZERO: assert property ( // [R1]
        (flags.t & ~MASK_T) == RST_ZERO)
        else $error("port T flag set on a pin without one");

    // ----------------------------------------------------------------
    // Port S
    // ----------------------------------------------------------------
    AST_S_ENABLE: assert property ( // [R3]
        wr_s_enable
        |=> enable.s == ($past(reg_wdata) & MASK_S))
        else $error("port S enable not written");

    AST_S_EDGE_SETS: assert property ( // [R4] [R17]
        pol_s[6] && sync2.s[6] && !prev.s[6]
        |=> flags.s[6])
        else $error("port S rising edge missed");

    AST_S_CLEAR: assert property ( // [R5]
        wr_s_flags && reg_wdata[5] && !edge_hit.s[5]
        |=> !flags.s[5])
        else $error("port S flag not cleared");

    AST_S_FLAG_HOLDS: assert property ( // [R12]
        flags.s[5] && !(wr_s_flags && reg_wdata[5])
        |=> flags.s[5])
        else $error("port S flag dropped without a clear");

    AST_S_MASKED: assert property ( // [R14]
        enable.s == RST_ZERO
        |=> !irq_port.s)
        else $error("port S request while disabled");

    // ----------------------------------------------------------------
    // Port AD
    // ----------------------------------------------------------------
    AST_AD_ENABLE: assert property ( // [R6]
        wr_ad_enable
        |=> enable.ad == $past(reg_wdata))
        else $error("port AD enable not written");

    AST_AD_FALL_SETS: assert property ( // [R7]
        !sync2.ad[4] && prev.ad[4]
        |=> flags.ad[4])
        else $error("port AD falling edge missed");

    AST_AD_FALL_ONLY: assert property ( // [R7]
        sync2.ad[0] && !prev.ad[0] && !flags.ad[0]
        |=> !flags.ad[0])
        else $error("port AD flag set on rising edge");

    AST_AD_CLEAR: assert property ( // [R8]
        wr_ad_flags && reg_wdata[3] && !edge_hit.ad[3]
        |=> !flags.ad[3])
        else $error("port AD flag not cleared");

    AST_AD_MASKED_SETS: assert property ( // [R14]
        !enable.ad[2] && edge_hit.ad[2]
        |=> flags.ad[2])
        else $error("masked port AD edge lost");

    AST_IRQ_TRACKS: assert property ( // [R13]
        irq_port.ad == |($past(next_flags.ad) & $past(enable.ad)))
        else $error("port AD request wrong");

    // ----------------------------------------------------------------
    // Port R
    // ----------------------------------------------------------------
    AST_R_ENABLE: assert property ( // [R9]
        wr_r_enable
        |=> enable.r == ($past(reg_wdata) & MASK_R))
        else $error("port R enable not written");

    AST_R_RISE_SETS: assert property ( // [R10] [R17]
        pol_r[1] && sync2.r[1] && !prev.r[1]
        |=> flags.r[1])
        else $error("port R rising edge missed");

    AST_R_WRONG_EDGE: assert property ( // [R10] [R17]
        pol_r[2] && !sync2.r[2] && prev.r[2] && !flags.r[2]
        |=> !flags.r[2])
        else $error("port R flag set on the inactive edge");

    AST_R_CLEAR: assert property ( // [R11]
        wr_r_flags && reg_wdata[0] && !edge_hit.r[0]
        |=> !flags.r[0])
        else $error("port R flag not cleared");

    AST_ZERO_KEEPS: assert property ( // [R12]
        wr_r_flags && !reg_wdata[2] && flags.r[2]
        |=> flags.r[2])
        else $error("writing zero changed a flag");

    AST_MASKED: assert property ( // [R14]
        enable.r == RST_ZERO
        |=> !irq_port.r)
        else $error("masked flag raised request");

    AST_SET_WINS: assert property ( // [R19]
        edge_hit.r[1] && wr_r_flags && reg_wdata[1]
        |=> flags.r[1])
        else $error("clear beat an edge");

    AST_R_PULL: assert property ( // [R17]
        wr_r_polarity
        |-> ##2 pull_down_sel.r == $past(reg_wdata, 2))
        else $error("port R pull selection wrong");

    // ----------------------------------------------------------------
    // Synchroniser and combined request
    // ----------------------------------------------------------------
    AST_SYNC_DELAY: assert property ( // [R18]
        edge_hit.ad[7]
        |=> !edge_hit.ad[7])
        else $error("one pin edge seen twice");

    AST_NO_EDGE_NO_SET: assert property ( // [R18]
        !edge_hit.r[3] && !flags.r[3]
        |=> !flags.r[3])
        else $error("port R flag set with no edge");

    AST_IRQ_ANY: assert property ( // [R13] [R19]
        irq == |($past(next_flags) & $past(enable)))
        else $error("combined request wrong");

    // ----------------------------------------------------------------
    // Coverage of the main scenarios
    // ----------------------------------------------------------------
    COV_T_FLAG: cover property (edge_hit.t[6] ##1 irq_port.t);
    COV_S_FLAG: cover property (edge_hit.s[5] ##1 flags.s[5]);
    COV_AD_FLAG: cover property (edge_hit.ad[2] ##[1:4] wr_ad_flags);
    COV_R_REQUEST: cover property (irq_port.r ##[1:8] !irq_port.r);
    COV_SET_CLEAR: cover property (edge_hit.r[1] && wr_r_flags && reg_wdata[1]);

endmodule

// *** testbench/port_pin_edge_interrupts_bench.sv ***
// Self-checking bench for the pin edge interrupt block.
// Assumes the pin model drives pin_in and the bench is the only register master.
`timescale 1ns/10ps
module port_pin_edge_interrupts_bench import ppei_pkg::*;;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    ppei_pins_s pin_in;
    ppei_pins_s pull_down_sel;
    ppei_irq_s irq_port;
    logic irq;
    int n_mismatch = 0;
    int checks_done = 0;
    logic [7:0] rv;

    always #25 clk = ~clk;

    ppei_pin_model pm (.clk(clk), .pins(pin_in));
    ppei_top dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in), .pull_down_sel(pull_down_sel),
        .irq_port(irq_port), .irq(irq));

    // ----------------------------------------------------------------
    // Register port and compares
    // ----------------------------------------------------------------
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp1(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    // Masked edge, zero write, enable, single-bit clear, then the wrong-direction edge
    task automatic edge_run(input int k, input logic [ADDR_W-1:0] en, input logic [ADDR_W-1:0] fl,
        input logic [ADDR_W-1:0] pol, input logic has_pol, input logic [7:0] m, input logic rise);
        logic [7:0] idle;
        idle = rise ? 8'h00 : 8'hff;
        if (has_pol) wr(pol, ~idle);
        wr(en, 8'h00);
        pm.set_byte(k, idle);
        repeat (5) @(posedge clk);
        wr(fl, 8'hff);
        pm.set_byte(k, ~idle);
        repeat (5) @(posedge clk);
        rd(fl, rv);
        cmp8("flags after active edge", m, rv);
        cmp1("masked port irq", 1'b0, irq_port[k]);
        cmp1("masked irq", 1'b0, irq);
        wr(fl, 8'h00);
        rd(fl, rv);
        cmp8("flags after zero write", m, rv);
        wr(en, 8'hff);
        rd(en, rv);
        cmp8("enable readback", m, rv);
        cmp1("port irq", 1'b1, irq_port[k]);
        cmp1("irq", 1'b1, irq);
        wr(fl, m & ~(m - 8'h01));
        rd(fl, rv);
        cmp8("flags after single clear", m & (m - 8'h01), rv);
        wr(fl, 8'hff);
        pm.set_byte(k, idle);
        repeat (5) @(posedge clk);
        rd(fl, rv);
        cmp8("flags after inactive edge", 8'h00, rv);
        cmp1("irq after clear", 1'b0, irq);
        wr(en, 8'h00);
    endtask

    task automatic reset_values();
        wr(4'he, 8'hff);
        for (int a = 0; a < 16; a++) begin
            rd(a[ADDR_W-1:0], rv);
            cmp8("reset or unmapped readback", 8'h00, rv);
        end
        cmp8("pull-down select after reset", 8'h00, pull_down_sel.t);
        cmp1("irq after reset", 1'b0, irq);
    endtask

    task automatic port_t_rising();
        edge_run(3, OFF_T_ENABLE, OFF_T_FLAGS, OFF_T_POLARITY, 1'b1, MASK_T, 1'b1);
        rd(OFF_T_POLARITY, rv);
        cmp8("port T polarity", 8'hff, rv);
        cmp8("port T pull-down select", 8'hff, pull_down_sel.t);
    endtask

    task automatic port_s_falling();
        edge_run(2, OFF_S_ENABLE, OFF_S_FLAGS, OFF_S_POLARITY, 1'b1, MASK_S, 1'b0);
        cmp8("port S pull-down select", 8'h00, pull_down_sel.s);
    endtask

    task automatic port_ad_falling();
        edge_run(1, OFF_AD_ENABLE, OFF_AD_FLAGS, OFF_AD_ENABLE, 1'b0, MASK_AD, 1'b0);
        cmp8("port AD pull-down select", 8'h00, pull_down_sel.ad);
    endtask

    task automatic port_r_rising();
        edge_run(0, OFF_R_ENABLE, OFF_R_FLAGS, OFF_R_POLARITY, 1'b1, MASK_R, 1'b1);
        cmp8("port R pull-down select", 8'hff, pull_down_sel.r);
    endtask

    // Rising edge on is seen on the very edge that samples a clearing write
    task automatic set_beats_clear();
        pm.set_byte(0, 8'h02);
        @(posedge clk);
        wr(OFF_R_FLAGS, 8'hff);
        rd(OFF_R_FLAGS, rv);
        cmp8("flag set beside a clear", 8'h02, rv);
        wr(OFF_R_ENABLE, 8'h02);
        rd(OFF_R_FLAGS, rv);
        cmp1("port R irq from surviving flag", 1'b1, irq_port.r);
        wr(OFF_R_FLAGS, 8'h02);
        rd(OFF_R_FLAGS, rv);
        cmp8("flag cleared afterwards", 8'h00, rv);
        cmp1("port R irq after clear", 1'b0, irq_port.r);
        wr(OFF_R_ENABLE, 8'h00);
    endtask

    // ----------------------------------------------------------------
    // Run control
    // ----------------------------------------------------------------
    task automatic tally_and_finish();
        if (n_mismatch == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        reset_values();
        port_t_rising();
        port_s_falling();
        port_ad_falling();
        port_r_rising();
        set_beats_clear();
        tally_and_finish();
    end

    // A hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        tally_and_finish();
    end
endmodule

// *** testbench/ppei_pin_model.sv ***
// Pin-side model: keys and signals on the input pins of ports T, S, AD and R.
// Assumes the bench asks for level changes; pins move just after a rising clock edge.
`timescale 1ns/10ps
module ppei_pin_model
    import ppei_pkg::*;
(
    // Clock
    input wire logic clk,
    // Pins towards the block
    output ppei_pins_s pins
);
    // Idle high, as with pull-ups under the falling-edge default
    initial pins = '1;

    // Frontplane drive on T is off AD digital input enable is set
    task automatic set_byte(input int k, input logic [7:0] v);
        @(posedge clk);
        pins[k*8 +: 8] <= v;
    endtask
endmodule
